// >>> rtl/slt_defines.svh
`ifndef SLT_DEFINES_SVH
`define SLT_DEFINES_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define SLT_CLK_KHZ 20000
`define SLT_DEB_MS 30
`define SLT_DEB_CYC (`SLT_DEB_MS * `SLT_CLK_KHZ)
`define SLT_TICK_MS 10
`define SLT_TICK_CYC (`SLT_TICK_MS * `SLT_CLK_KHZ)
`define SLT_PULSE_MS 10
`define SLT_PULSE_CYC (`SLT_PULSE_MS * `SLT_CLK_KHZ)
`define SLT_SHORT_TICKS 5'h05
`define SLT_ARM_OFF 7'h0d
`define SLT_SFLASH_ON 7'h0d
`define SLT_FEW_ON 9'h005
`define SLT_RUN_LAST 3'h4
// ----------------------------------------
// Register map
// ----------------------------------------
`define SLT_OFF_CTRL 4'h0
`define SLT_OFF_STAT 4'h4
`define SLT_CTRL_RST 5'h00
`define SLT_CTRL_LOGGER 0
`define SLT_CTRL_RISING 1
`define SLT_CTRL_DEFER 2
`define SLT_CTRL_STOP 3
`define SLT_CTRL_PULSE 4
`endif

// >>> rtl/slt_pkg.sv
package slt_pkg;
	// Gray order along idle, armed, logging, stopped
	typedef enum logic [1:0]
	{
		slt_idle = 2'h0,
		slt_armed = 2'h1,
		slt_logging = 2'h3,
		slt_stopped = 2'h2
	} slt_log_t;
endpackage

// >>> rtl/slt_status.sv
// Local design decisions: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "slt_defines.svh"
// Operation
// - Interface mode: channel yellow LED short-flashes on each message sent or received.
// - Interface mode: error passive blinks channel LED and red LED.
// - Interface mode: bus off blinks channel LED and red LED slowly.
// - Interface mode: orange LED short-flashes on error frames from either channel.
// - Logger fault: red steady, orange repeats one to five flashes by fault kind.
// - Armed waiting for trigger: green 90 percent on, 10 percent off.
// - Actively logging traffic: green flashes.
// - Stopped by trigger: leave bus, green blinks slowly 50/50.
// - Talking to configuration tool: running light across all LEDs.
// - Disk activity in configuration mode: orange LED blinks.
// - No disk and no USB: all LEDs blink slowly together.
// - Logger without USB: green flashes once every few seconds.
// - Firmware configuration error: green flashes, red steady.
// - Trigger edge selectable: falling fires on grounding, rising on release.
// - Trigger debounced; level must persist about 30 ms, shorter pulses ignored.
// - Optional output pulse on trigger line when enabled.
// - Logger starts at power-up or waits for trigger, per configuration.
// - Interface mode: green steady while connected.
// - Logger mode: channel LED lights on that channel's traffic.
// - Waiting for USB: green flashes slowly; steady once connected. Here in interface mode only; an idle logger short-flashes green even with USB.
module slt_status #(
	parameter int DEB_CYC = `SLT_DEB_CYC,
	parameter int TICK_CYC = `SLT_TICK_CYC,
	parameter int PULSE_CYC = `SLT_PULSE_CYC
)(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register bus
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Internal conditions
	input wire logic [1:0] can_act,
	input wire logic [1:0] err_passive,
	input wire logic [1:0] bus_off,
	input wire logic err_frame,
	input wire logic [2:0] fault_code,
	input wire logic fw_cfg_err,
	input wire logic tool_link,
	input wire logic disk_busy,
	input wire logic disk_present,
	input wire logic usb_link,
	// Trigger pins
	input wire logic trig_pin,
	output logic trig_out,
	// Logging control
	output slt_pkg::slt_log_t log_state,
	output logic off_bus,
	// Indicators
	output logic power_status_led,
	output logic first_channel_led,
	output logic second_channel_led,
	output logic error_led,
	output logic transient_led_a
);
	import slt_pkg::*;

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	logic ack;
	logic [4:0] ctrl;
	logic [4:0] leds;
	logic trig_s1, trig_s2, deb_lvl, deb_prev;
	wire req = read | write;
	wire sel_ctrl = address == `SLT_OFF_CTRL;
	wire sel_stat = address == `SLT_OFF_STAT;
	wire ctrl_we = write & ack & sel_ctrl & byteenable[0];
	wire [31:0] stat_word = {23'h000000, leds, trig_out, deb_lvl, log_state};
	wire [31:0] rd_mux = sel_ctrl ? {27'h0000000, ctrl} : (sel_stat ? stat_word : 32'h00000000);
	wire ctrl_logger = ctrl[`SLT_CTRL_LOGGER];
	wire ctrl_rising = ctrl[`SLT_CTRL_RISING];
	wire ctrl_defer = ctrl[`SLT_CTRL_DEFER];
	wire ctrl_stop = ctrl[`SLT_CTRL_STOP];
	wire ctrl_pulse = ctrl[`SLT_CTRL_PULSE];

	// One wait cycle; unmapped reads give zero
	assign waitrequest = req & ~ack;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ack <= 1'b0;
			readdata <= 32'h00000000;
			ctrl <= `SLT_CTRL_RST;
		end
		else
		begin
			ack <= req & ~ack;
			if (read & ~ack)
				readdata <= rd_mux;
			if (ctrl_we)
				ctrl <= writedata[4:0];
		end
	end

	// ----------------------------------------
	// Trigger input
	// ----------------------------------------
	logic [19:0] deb_cnt;
	wire deb_done = deb_cnt == 20'(DEB_CYC - 1);
	wire trig_fire = (deb_prev != deb_lvl) && (deb_lvl == ctrl_rising);

	// Open input reads high, so idle level is one
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			trig_s1 <= 1'b1;
			trig_s2 <= 1'b1;
			deb_lvl <= 1'b1;
			deb_prev <= 1'b1;
			deb_cnt <= 20'h00000;
		end
		else
		begin
			trig_s1 <= trig_pin;
			trig_s2 <= trig_s1;
			deb_prev <= deb_lvl;
			if (trig_s2 == deb_lvl)
				deb_cnt <= 20'h00000;
			else if (deb_done)
			begin
				deb_lvl <= trig_s2;
				deb_cnt <= 20'h00000;
			end
			else
				deb_cnt <= deb_cnt + 20'h00001;
		end
	end

	a_deb_persist: assert property (@(posedge clk) disable iff (!rst_n)
		(deb_lvl != $past(deb_lvl)) |-> $past(deb_done))
		else $error("debounced level changed early");
	a_trig_edge: assert property (@(posedge clk) disable iff (!rst_n)
		trig_fire |-> $past(trig_s2) == ctrl_rising && $past(deb_lvl) != ctrl_rising)
		else $error("trigger on wrong edge");

	// ----------------------------------------
	// Logging state
	// ----------------------------------------
	slt_log_t next_log;
	slt_log_t step_log;
	wire log_go = ctrl_logger && fault_code == 3'h0 && !fw_cfg_err;

	always_comb
	begin
		step_log = log_state;
		unique case (log_state)
			slt_idle:
				if (log_go)
					step_log = ctrl_defer ? slt_armed : slt_logging;
			slt_armed:
				if (trig_fire)
					step_log = slt_logging;
			slt_logging:
				if (trig_fire && ctrl_stop)
					step_log = slt_stopped;
			slt_stopped:
				step_log = slt_stopped;
		endcase
	end

	assign next_log = ctrl_logger ? step_log : slt_idle;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			log_state <= slt_idle;
			off_bus <= 1'b0;
		end
		else
		begin
			log_state <= next_log;
			off_bus <= next_log == slt_stopped;
		end
	end

	a_arm_start: assert property (@(posedge clk) disable iff (!rst_n)
		(log_state == slt_idle && log_go) |=> log_state == ($past(ctrl_defer) ? slt_armed : slt_logging))
		else $error("logging start choice wrong");
	a_stop_off_bus: assert property (@(posedge clk) disable iff (!rst_n)
		(log_state == slt_logging && trig_fire && ctrl_stop && ctrl_logger)
		|=> log_state == slt_stopped && off_bus)
		else $error("trigger stop did not leave bus");

	// ----------------------------------------
	// Trigger output pulse
	// ----------------------------------------
	logic [19:0] pulse_cnt;
	wire [19:0] next_pulse = (trig_fire && ctrl_pulse) ? 20'(PULSE_CYC) :
		(pulse_cnt != 20'h00000 ? pulse_cnt - 20'h00001 : 20'h00000);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pulse_cnt <= 20'h00000;
			trig_out <= 1'b0;
		end
		else
		begin
			pulse_cnt <= next_pulse;
			trig_out <= next_pulse != 20'h00000;
		end
	end

	a_pulse_fire: assert property (@(posedge clk) disable iff (!rst_n)
		(trig_fire && ctrl_pulse) |=> trig_out [*2])
		else $error("trigger pulse missing");

	// ----------------------------------------
	// Pattern timebase
	// ----------------------------------------
	// Single 10 ms tick feeds every pattern, so all periods stay locked
	logic [19:0] tick_cnt;
	logic [8:0] ph;
	logic [2:0] run_idx;
	wire tick = tick_cnt == 20'(TICK_CYC - 1);
	wire run_step = tick && ph[4:0] == 5'h1f;
	wire p_flash = ph[3];
	wire p_blink = ph[4];
	wire p_slow = ph[6];
	wire p_sflash = ph[6:0] < `SLT_SFLASH_ON;
	wire p_arm = ph[6:0] >= `SLT_ARM_OFF;
	wire p_few = ph[8:0] < `SLT_FEW_ON;
	wire p_group = (ph[8:5] < {1'b0, fault_code}) && !ph[4];

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			tick_cnt <= 20'h00000;
			ph <= 9'h000;
			run_idx <= 3'h0;
		end
		else
		begin
			tick_cnt <= tick ? 20'h00000 : tick_cnt + 20'h00001;
			if (tick)
				ph <= ph + 9'h001;
			if (run_step)
				run_idx <= (run_idx == `SLT_RUN_LAST) ? 3'h0 : run_idx + 3'h1;
		end
	end

	// ----------------------------------------
	// Short-flash stretchers
	// ----------------------------------------
	// Back-to-back events keep the LED lit, so heavy load looks steady
	wire [2:0] ev = {err_frame, can_act};
	logic [2:0] st_on;

	for (genvar i = 0; i < 3; i++)
	begin : g_st
		logic [4:0] st;
		always_ff @(posedge clk)
		begin
			if (!rst_n)
				st <= 5'h00;
			else if (ev[i])
				st <= `SLT_SHORT_TICKS;
			else if (tick && st != 5'h00)
				st <= st - 5'h01;
		end
		assign st_on[i] = st != 5'h00;
		a_flash_stretch: assert property (@(posedge clk) disable iff (!rst_n)
			ev[i] |=> st_on[i] [*3])
			else $error("event flash not stretched");
	end

	// ----------------------------------------
	// Indicator selection
	// ----------------------------------------
	wire lost = !disk_present && !usb_link;
	wire tool = tool_link && !lost;
	wire fwe = fw_cfg_err && !lost && !tool;
	wire fault = fault_code != 3'h0;
	logic [1:0] chan_nxt;

	// Bus off over error passive over traffic
	for (genvar c = 0; c < 2; c++)
	begin : g_ch
		wire iface = bus_off[c] ? p_slow : (err_passive[c] ? p_blink : st_on[c]);
		assign chan_nxt[c] = ctrl_logger ? st_on[c] : iface;
	end

	wire err_if = (|bus_off) ? p_slow : ((|err_passive) & p_blink);
	wire err_norm = ctrl_logger ? fault : err_if;
	wire transient_led_a_norm = ctrl_logger ? (fault & p_group) : st_on[2];
	wire grn_if = usb_link ? 1'b1 : p_sflash;
	logic grn_log;

	always_comb
	begin
		unique case (log_state)
			slt_armed: grn_log = p_arm;
			slt_logging: grn_log = p_flash;
			slt_stopped: grn_log = p_slow;
			slt_idle: grn_log = usb_link ? p_sflash : p_few;
		endcase
	end

	wire grn_norm = ctrl_logger ? grn_log : grn_if;
	// Order {green, ch1, ch2, red, orange}
	wire [4:0] run_leds = 5'h10 >> run_idx;
	wire [4:0] tool_leds = {run_leds[4:1], disk_busy ? p_blink : run_leds[0]};
	wire [4:0] norm_leds = {grn_norm, chan_nxt[0], chan_nxt[1], err_norm, transient_led_a_norm};
	wire [4:0] fwe_leds = {p_flash, chan_nxt[0], chan_nxt[1], 1'b1, transient_led_a_norm};
	wire [4:0] next_leds = lost ? {5{p_slow}} : (tool ? tool_leds : (fwe ? fwe_leds : norm_leds));

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			leds <= 5'h00;
		else
			leds <= next_leds;
	end

	assign power_status_led = leds[4];
	assign first_channel_led = leds[3];
	assign second_channel_led = leds[2];
	assign error_led = leds[1];
	assign transient_led_a = leds[0];

	a_all_slow: assert property (@(posedge clk) disable iff (!rst_n)
		lost |=> leds == {5{$past(p_slow)}})
		else $error("lost disk pattern wrong");
	a_passive_blink: assert property (@(posedge clk) disable iff (!rst_n)
		(!lost && !tool && !fwe && !ctrl_logger && err_passive[0] && bus_off == 2'h0)
		|=> first_channel_led == $past(p_blink) && error_led == $past(p_blink))
		else $error("error passive blink wrong");
	a_busoff_slow: assert property (@(posedge clk) disable iff (!rst_n)
		(!lost && !tool && !fwe && !ctrl_logger && bus_off[1])
		|=> second_channel_led == $past(p_slow) && error_led == $past(p_slow))
		else $error("bus off blink wrong");
	a_fault_red: assert property (@(posedge clk) disable iff (!rst_n)
		(!lost && !tool && ctrl_logger && fault)
		|=> error_led && transient_led_a == $past(p_group))
		else $error("logger fault pattern wrong");
	a_armed_green: assert property (@(posedge clk) disable iff (!rst_n)
		(!lost && !tool && !fwe && ctrl_logger && log_state == slt_armed)
		|=> power_status_led == $past(p_arm))
		else $error("armed duty pattern wrong");
	a_iface_green: assert property (@(posedge clk) disable iff (!rst_n)
		(!lost && !tool && !fwe && !ctrl_logger && usb_link) |=> power_status_led)
		else $error("interface green not steady");
endmodule

// >>> test/slt_switch.sv
`timescale 1ns/1ps
module slt_switch (
	// Clock
	input wire logic clk,
	// Trigger line
	output logic trig_pin
);
	// Open switch leaves the line at its pull-up level
	initial trig_pin = 1'b1;
	task press(input int n);
		@(posedge clk);
		trig_pin <= 1'b0;
		repeat (n) @(posedge clk);
		trig_pin <= 1'b1;
	endtask
endmodule

// >>> test/slt_testbench.sv
`timescale 1ns/1ps
module testbench;
	import slt_pkg::*;
	logic clk, rst_n, read, write, waitrequest, err_frame, fw_cfg_err, tool_link, disk_busy, disk_present, usb_link;
	logic [3:0] address, byteenable;
	logic [31:0] writedata, readdata, q, rnd;
	logic [1:0] can_act, err_passive, bus_off;
	logic [2:0] fault_code;
	logic trig_pin, trig_out, off_bus, g_led, c1_led, c2_led, r_led, o_led, last;
	logic [4:0] leds;
	slt_log_t log_state;
	int err_count, checks_done, cyc, seed, m_state, m_ctrl, hi, rises, eq;
	assign leds = {g_led, c1_led, c2_led, r_led, o_led};
	// Short counts keep the run within reach
	slt_status #(.DEB_CYC(20), .TICK_CYC(4), .PULSE_CYC(8)) slt_status_i (.clk(clk), .rst_n(rst_n),
		.address(address), .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .can_act(can_act), .err_passive(err_passive),
		.bus_off(bus_off), .err_frame(err_frame), .fault_code(fault_code), .fw_cfg_err(fw_cfg_err),
		.tool_link(tool_link), .disk_busy(disk_busy), .disk_present(disk_present), .usb_link(usb_link),
		.trig_pin(trig_pin), .trig_out(trig_out), .log_state(log_state), .off_bus(off_bus),
		.power_status_led(g_led), .first_channel_led(c1_led), .second_channel_led(c2_led),
		.error_led(r_led), .transient_led_a(o_led));
	slt_switch slt_switch_i (.clk(clk), .trig_pin(trig_pin));
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 40000)
		begin
			err_count++;
			complete_run;
		end
	end
	// ----------------------------------------
	// Model and tasks
	// ----------------------------------------
	function automatic int next_state(int s, int c, bit fire);
		if (c[0] == 0)
			return 0;
		if (s == 0)
			return (fault_code != 0 || fw_cfg_err) ? 0 : (c[2] ? 1 : 3);
		if (fire && s == 1)
			return 3;
		if (fire && s == 3 && c[3])
			return 2;
		return s;
	endfunction
	task complete_run;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
			err_count++;
		end
	endtask
	// Holds the request until waitrequest is seen low
	task bus(input logic rd, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge clk);
		address <= a;
		writedata <= d;
		byteenable <= be;
		read <= rd;
		write <= ~rd;
		@(posedge clk);
		while (waitrequest !== 1'b0)
			@(posedge clk);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (!rd && a == 4'h0 && be[0])
			m_ctrl = d[4:0];
		m_state = next_state(m_state, m_ctrl, 1'b0);
	endtask
	// Whole pattern periods make the counts independent of phase
	task meas(input int idx, input int n);
		hi = 0;
		rises = 0;
		eq = 0;
		repeat (4) @(negedge clk);
		last = leds[idx];
		repeat (n)
		begin
			@(negedge clk);
			hi += (leds[idx] === 1'b1);
			rises += (leds[idx] === 1'b1 && last === 1'b0);
			eq += (leds === 5'h00 || leds === 5'h1f);
			last = leds[idx];
		end
	endtask
	task trig(input int n, input bit fire);
		hi = 0;
		fork
			slt_switch_i.press(n);
			repeat (100) @(negedge clk) hi += (trig_out === 1'b1);
		join
		m_state = next_state(m_state, m_ctrl, fire);
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial
	begin
		{rst_n, read, write, err_frame, fw_cfg_err, tool_link, disk_busy} = 7'h00;
		{disk_present, usb_link, address, byteenable, writedata} = 42'h0;
		{can_act, err_passive, bus_off, fault_code} = 9'h000;
		disk_present = 1'b1;
		usb_link = 1'b1;
		seed = 4647;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		bus(1'b1, 4'h0, 32'h0, 4'hf);
		chk(q, 32'h0);
		bus(1'b0, 4'h4, 32'hff, 4'hf);
		bus(1'b1, 4'h4, 32'h0, 4'hf);
		chk(q, 32'h104);
		bus(1'b1, 4'h8, 32'h0, 4'hf);
		chk(q, 32'h0);
		rnd = $random(seed);
		bus(1'b0, 4'h0, rnd, 4'he);
		bus(1'b1, 4'h0, 32'h0, 4'hf);
		chk(q, 32'(m_ctrl));
		bus(1'b0, 4'h0, rnd, 4'hf);
		bus(1'b1, 4'h0, 32'h0, 4'hf);
		chk(q, 32'(m_ctrl));
		bus(1'b0, 4'h0, 32'h0, 4'h1);
		$display("test 1 done");
		bus(1'b0, 4'h0, 32'h5, 4'h1);
		repeat (2) @(negedge clk);
		chk(32'(log_state), 32'(m_state));
		meas(4, 512);
		chk(32'(hi), 32'd460);
		trig(10, 1'b0);
		chk(32'(log_state), 32'(m_state));
		trig(40, 1'b1);
		chk(32'(log_state), 32'(m_state));
		$display("test 2 done");
		bus(1'b0, 4'h0, 32'h1b, 4'h1);
		trig(40, 1'b1);
		chk(32'(hi), 32'd8);
		chk(32'(log_state), 32'(m_state));
		chk({31'h0, off_bus}, 32'h1);
		meas(4, 512);
		chk(32'(hi), 32'd256);
		$display("test 3 done");
		for (int c = 1; c <= 5; c++)
		begin
			bus(1'b0, 4'h0, 32'h0, 4'h1);
			fault_code <= c[2:0];
			bus(1'b0, 4'h0, 32'h1, 4'h1);
			meas(0, 2048);
			chk(32'(rises), 32'(c));
			chk({31'h0, r_led}, 32'h1);
			chk(32'(log_state), 32'(m_state));
		end
		@(posedge clk);
		usb_link <= 1'b0;
		meas(4, 2048);
		chk(32'(hi), 32'd20);
		@(posedge clk);
		usb_link <= 1'b1;
		fault_code <= 3'h0;
		fw_cfg_err <= 1'b1;
		meas(1, 512);
		chk(32'(hi), 32'd512);
		meas(4, 512);
		chk(32'(hi), 32'd256);
		@(posedge clk);
		fw_cfg_err <= 1'b0;
		bus(1'b0, 4'h0, 32'h0, 4'h1);
		$display("test 4 done");
		fork
			meas(4, 512);
			repeat (520) @(posedge clk)
			begin
				can_act <= 2'($random(seed));
				err_frame <= 1'($random(seed));
			end
		join
		chk(32'(hi), 32'd512);
		can_act <= 2'h0;
		err_frame <= 1'b0;
		repeat (30) @(posedge clk);
		for (int k = 0; k < 3; k++)
		begin
			fork
				meas(k == 0 ? 3 : (k == 1 ? 2 : 0), 64);
				begin
					repeat (8) @(posedge clk);
					{err_frame, can_act} <= 3'h1 << k;
					@(posedge clk);
					{err_frame, can_act} <= 3'h0;
				end
			join
			chk(32'(rises), 32'h1);
			chk(32'(hi >= 17 && hi <= 20), 32'h1);
		end
		@(posedge clk);
		err_passive <= 2'h1;
		meas(3, 512);
		chk(32'(rises), 32'h4);
		@(posedge clk);
		bus_off <= 2'h2;
		meas(1, 512);
		chk(32'(rises), 32'h1);
		chk(32'(hi), 32'd256);
		meas(3, 512);
		chk(32'(rises), 32'h4);
		@(posedge clk);
		err_passive <= 2'h0;
		bus_off <= 2'h0;
		usb_link <= 1'b0;
		meas(4, 512);
		chk(32'(hi), 32'd52);
		@(posedge clk);
		usb_link <= 1'b1;
		tool_link <= 1'b1;
		meas(4, 640);
		chk(32'(hi), 32'd128);
		@(posedge clk);
		disk_busy <= 1'b1;
		meas(0, 512);
		chk(32'(rises), 32'h4);
		@(posedge clk);
		tool_link <= 1'b0;
		disk_busy <= 1'b0;
		disk_present <= 1'b0;
		usb_link <= 1'b0;
		meas(4, 512);
		chk(32'(hi), 32'd256);
		chk(32'(eq), 32'd512);
		$display("test 5 done");
		complete_run;
	end
endmodule
